/* File: miw_edge_det.sv */
// Edge detector: per-line event pulses with polarity and either-edge select.
module miw_edge_det #(
  parameter int N = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  miw_edge_if.det edgeBus
);
  logic [N-1:0] prev_reg;
  logic [N-1:0] evt_next;

  // Tracks the pin through reset too, so a line held high gives no false edge after release
  always_ff @(posedge clk) begin
    prev_reg <= edgeBus.lineIn;
  end

  for (genvar i = 0; i < N; i++) begin : g_line
    logic rise;
    logic fall;
    logic evt;
    miw_pkg::miw_edge_t sel;
    assign sel = miw_pkg::miw_edge_t'(edgeBus.edgeSel[2*i +: 2]);
    assign rise = edgeBus.lineIn[i] & ~prev_reg[i];
    assign fall = ~edgeBus.lineIn[i] & prev_reg[i];
    always_comb begin
      unique case (sel)
        // Inversion swaps the active edge only for single-edge mode
        miw_pkg::EDGE_RISE: evt = edgeBus.invert[i] ? fall : rise;
        miw_pkg::EDGE_FALL: evt = edgeBus.invert[i] ? rise : fall;
        miw_pkg::EDGE_EITHER: evt = rise | fall;
        miw_pkg::EDGE_NONE: evt = 1'b0;
      endcase
    end
    assign evt_next[i] = evt;
  end

  assign edgeBus.eventPulse = evt_next;
endmodule : miw_edge_det

/* File: miw_edge_if.sv */
// Interface: event detector link between top and edge detector.
interface miw_edge_if #(
  parameter int N = 4
);
  logic [N-1:0] lineIn;
  logic [N-1:0] invert;
  logic [2*N-1:0] edgeSel;
  logic [N-1:0] eventPulse;
  modport det (input lineIn, input invert, input edgeSel, output eventPulse);
  modport top (output lineIn, output invert, output edgeSel, input eventPulse);
endinterface : miw_edge_if

/* File: miw_host_model.sv */
// Host chipset model: resolves the interrupt and wake pins.
module miw_host_model (
  input wire logic mgmtIrqPinOut,
  input wire logic mgmtIrqPinOe,
  input wire logic wakePinOut,
  input wire logic wakePinOe,
  output logic mgmtIrqLevel,
  output logic wakeLevel
);
  // Board pull-ups, so a released pin reads high rather than a stale value
  assign mgmtIrqLevel = mgmtIrqPinOe ? mgmtIrqPinOut : 1'b1;
  assign wakeLevel = wakePinOe ? wakePinOut : 1'b1;
endmodule : miw_host_model

/* File: miw_irq_wake.sv */
// Top: interrupt and wake event aggregation for group 7.
// Contract
// - Sleep control 2 bits 1:0 and 7:6 read zero; bits 4:2 are storage.
// - Sleep control 2 bit 5 reads zero; writing one is an interrupt event.
// - That write sets status bit 5 of interrupt status 7.
// - Status 7 bits: gpio 0-3, keyboard pin 4, sleep write 5; write-one clears.
// - Interrupt enable 7 bits 0-5 gate sources onto group interrupt.
// - Wake status bits 0-3 set on gpio events regardless of enables.
// - Wake status survives main resets; cleared only by standby power-on reset.
// - Writing one to wake status bits 4:0 clears; zero leaves unchanged.
// - Disabled wake source still recorded but does not assert wake pin.
// - Either-edge mode sets wake, interrupt and misc status on both edges.
// - Polarity inversion does not affect alt clock or either-edge detection.
// - Interrupt pin inactive if group interrupt inactive or master enable zero.
// - Inactive interrupt pin floats if open-drain, drives high if push-pull.
// - Keyboard function 17 on both lines 20 and 62 works only on 62.
module miw_irq_wake #(
  parameter int NUM_GPIO = miw_pkg::NUM_GPIO
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic standbyPorRst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic [NUM_GPIO-1:0] gpioLine,
  input wire logic kbdPortPin16,
  input wire logic kbdPortPin17,
  output logic mgmtIrqPinOut,
  output logic mgmtIrqPinOe,
  output logic wakePinOut,
  output logic wakePinOe,
  output logic kbdPin17OnLine20,
  output logic kbdPin17OnLine62,
  output logic miscStatusPulse,
  output logic irqOut
);
  logic [7:0] sleepCtrl_reg;
  logic [7:0] irqStatus_reg;
  logic [7:0] irqEnable_reg;
  logic [7:0] wakeStatus_reg;
  logic [7:0] wakeEnable_reg;
  logic [7:0] groupCtrl_reg;
  logic [7:0] gpioCfg_reg;
  logic [7:0] kbdCfg_reg;
  logic [7:0] irqStatus_next;
  logic [7:0] wakeStatus_next;
  logic [7:0] rdata_next;
  logic kbdPrev_reg;
  logic kbdEvent;
  logic sleepWriteEvent;
  logic groupIrq;
  logic groupWake;
  logic irqActive;
  logic [NUM_GPIO-1:0] gpioEvent;
  logic [7:0] srcEvents;

  miw_edge_if #(.N(NUM_GPIO)) edgeBus ();

  assign edgeBus.lineIn = gpioLine;
  // Low nibble of gpio config: inversion; edge select in gpio cfg bits 7:4 plus kbd cfg bits 7:4
  assign edgeBus.invert = gpioCfg_reg[NUM_GPIO-1:0];
  assign edgeBus.edgeSel = {kbdCfg_reg[7:4], gpioCfg_reg[7:4]};
  assign gpioEvent = edgeBus.eventPulse;

  miw_edge_det #(.N(NUM_GPIO)) u_edge (
    .clk(clk),
    .sys_rst(sys_rst),
    .edgeBus(edgeBus)
  );

  logic wrSleep;
  logic wrIrqSts;
  logic wrWakeSts;
  assign wrSleep = regWrite && (regAddr == miw_pkg::SLEEP_CONTROL_2_OFS);
  assign wrIrqSts = regWrite && (regAddr == miw_pkg::MGMT_IRQ_STATUS_7_OFS);
  assign wrWakeSts = regWrite && (regAddr == miw_pkg::WAKE_STATUS_7_OFS);

  assign sleepWriteEvent = wrSleep && regWdata[miw_pkg::SLEEP_EVENT_BIT];
  assign kbdEvent = kbdPortPin16 & ~kbdPrev_reg;
  assign srcEvents = {2'b00, sleepWriteEvent, kbdEvent, gpioEvent};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      kbdPrev_reg <= 1'b0;
    end else begin
      kbdPrev_reg <= kbdPortPin16;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sleepCtrl_reg <= miw_pkg::REG_RESET;
    end else if (wrSleep) begin
      sleepCtrl_reg <= regWdata & miw_pkg::SLEEP_RW_MASK;
    end
  end

  always_comb begin
    irqStatus_next = irqStatus_reg;
    if (wrIrqSts) begin
      irqStatus_next = irqStatus_next & ~regWdata;
    end
    // Set wins over a same-cycle clear
    irqStatus_next = (irqStatus_next | srcEvents) & miw_pkg::IRQ_MASK;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqStatus_reg <= miw_pkg::REG_RESET;
    end else begin
      irqStatus_reg <= irqStatus_next;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqEnable_reg <= miw_pkg::REG_RESET;
      wakeEnable_reg <= miw_pkg::REG_RESET;
      groupCtrl_reg <= miw_pkg::REG_RESET;
      gpioCfg_reg <= miw_pkg::REG_RESET;
      kbdCfg_reg <= miw_pkg::REG_RESET;
    end else if (regWrite) begin
      unique case (regAddr)
        miw_pkg::MGMT_IRQ_ENABLE_7_OFS: irqEnable_reg <= regWdata & miw_pkg::IRQ_MASK;
        miw_pkg::WAKE_ENABLE_7_OFS: wakeEnable_reg <= regWdata & miw_pkg::WAKE_SRC_MASK;
        miw_pkg::GROUP_CTRL_OFS: groupCtrl_reg <= regWdata;
        miw_pkg::GPIO_CFG_OFS: gpioCfg_reg <= regWdata;
        miw_pkg::KBD_CFG_OFS: kbdCfg_reg <= regWdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    wakeStatus_next = wakeStatus_reg;
    if (wrWakeSts) begin
      wakeStatus_next = wakeStatus_next & ~(regWdata & miw_pkg::WAKE_W1C_MASK);
    end
    // No enable term here: status records every gpio event
    wakeStatus_next = wakeStatus_next | {4'h0, gpioEvent};
  end

  // Only the standby power-on reset touches wake status, not sys_rst
  always_ff @(posedge clk) begin
    if (standbyPorRst) begin
      wakeStatus_reg <= miw_pkg::REG_RESET;
    end else begin
      wakeStatus_reg <= wakeStatus_next;
    end
  end

  assign groupIrq = |(irqStatus_reg & irqEnable_reg & miw_pkg::IRQ_MASK);
  assign groupWake = |(wakeStatus_reg & wakeEnable_reg)
    && groupCtrl_reg[miw_pkg::WAKE_MASTER_BIT];
  assign irqActive = groupIrq && groupCtrl_reg[miw_pkg::IRQ_MASTER_BIT];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mgmtIrqPinOut <= 1'b1;
      mgmtIrqPinOe <= 1'b0;
    end else begin
      mgmtIrqPinOut <= ~irqActive;
      // Open-drain releases when idle; push-pull drives high
      mgmtIrqPinOe <= irqActive || !groupCtrl_reg[miw_pkg::OPEN_DRAIN_BIT];
    end
  end

  // Wake pin is open-drain: driven only while asserted
  always_ff @(posedge clk) begin
    if (standbyPorRst) begin
      wakePinOut <= 1'b1;
      wakePinOe <= 1'b0;
    end else begin
      wakePinOut <= ~groupWake;
      wakePinOe <= groupWake;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      kbdPin17OnLine20 <= 1'b0;
      kbdPin17OnLine62 <= 1'b0;
    end else begin
      // Line 62 wins when both lines select function 17
      kbdPin17OnLine62 <= groupCtrl_reg[2] && kbdPortPin17;
      kbdPin17OnLine20 <= groupCtrl_reg[1] && !groupCtrl_reg[2] && kbdPortPin17;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      miscStatusPulse <= 1'b0;
      irqOut <= 1'b0;
    end else begin
      miscStatusPulse <= |gpioEvent;
      irqOut <= groupIrq;
    end
  end

  always_comb begin
    unique case (regAddr)
      miw_pkg::SLEEP_CONTROL_2_OFS: rdata_next = sleepCtrl_reg & miw_pkg::SLEEP_RW_MASK;
      miw_pkg::MGMT_IRQ_STATUS_7_OFS: rdata_next = irqStatus_reg;
      miw_pkg::MGMT_IRQ_ENABLE_7_OFS: rdata_next = irqEnable_reg;
      miw_pkg::WAKE_STATUS_7_OFS: rdata_next = wakeStatus_reg;
      miw_pkg::WAKE_ENABLE_7_OFS: rdata_next = wakeEnable_reg;
      miw_pkg::GROUP_CTRL_OFS: rdata_next = groupCtrl_reg;
      miw_pkg::GPIO_CFG_OFS: rdata_next = gpioCfg_reg;
      miw_pkg::KBD_CFG_OFS: rdata_next = kbdCfg_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= regRead ? rdata_next : 8'h00;
    end
  end

  a_sleep_sets_status: assert property (@(posedge clk) disable iff (sys_rst)
    sleepWriteEvent |=> irqStatus_reg[5]) else $error("sleep write did not set status");
  a_sleep_read_zero: assert property (@(posedge clk) disable iff (sys_rst)
    $past(regRead) && $past(regAddr) == 8'h61 |-> (regRdata & 8'he3) == 8'h00)
    else $error("sleep ctrl reserved bits nonzero");
  a_irq_clear_w1c: assert property (@(posedge clk) disable iff (sys_rst)
    wrIrqSts && regWdata[0] && !gpioEvent[0] |=> !irqStatus_reg[0])
    else $error("status bit not cleared");
  a_wake_sets_any: assert property (@(posedge clk) disable iff (standbyPorRst)
    gpioEvent[0] |=> wakeStatus_reg[0]) else $error("wake status not set");
  a_wake_zero_keeps: assert property (@(posedge clk) disable iff (standbyPorRst)
    wrWakeSts && regWdata == 8'h00 && gpioEvent == '0
    |=> wakeStatus_reg == $past(wakeStatus_reg))
    else $error("zero write changed wake status");
  a_wake_keeps_rst: assert property (@(posedge clk) disable iff (standbyPorRst)
    sys_rst && !wrWakeSts |=> (wakeStatus_reg & $past(wakeStatus_reg)) == $past(wakeStatus_reg))
    else $error("wake status lost on reset");
  a_irq_pin_master: assert property (@(posedge clk) disable iff (sys_rst)
    !groupCtrl_reg[7] |=> mgmtIrqPinOut) else $error("irq pin active without master");
  a_irq_pin_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !irqActive && !groupCtrl_reg[0] |=> mgmtIrqPinOe && mgmtIrqPinOut)
    else $error("push-pull idle not high");
  a_wake_disabled: assert property (@(posedge clk) disable iff (standbyPorRst)
    wakeEnable_reg == 8'h00 |=> !wakePinOe) else $error("wake pin active while disabled");
  a_kbd17_priority: assert property (@(posedge clk) disable iff (sys_rst)
    groupCtrl_reg[2] |=> !kbdPin17OnLine20) else $error("function 17 on both lines");
endmodule : miw_irq_wake

/* File: miw_pkg.sv */
// Package: register map, field positions and reset values for the wake/irq group.
package miw_pkg;
  localparam logic [7:0] SLEEP_CONTROL_2_OFS = 8'h61;
  localparam logic [7:0] MGMT_IRQ_STATUS_7_OFS = 8'h64;
  localparam logic [7:0] MGMT_IRQ_ENABLE_7_OFS = 8'h66;
  localparam logic [7:0] WAKE_STATUS_7_OFS = 8'h68;
  localparam logic [7:0] WAKE_ENABLE_7_OFS = 8'h6c;
  localparam logic [7:0] GROUP_CTRL_OFS = 8'h70;
  localparam logic [7:0] GPIO_CFG_OFS = 8'h71;
  localparam logic [7:0] KBD_CFG_OFS = 8'h72;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] SLEEP_RW_MASK = 8'h1c;
  localparam logic [7:0] IRQ_MASK = 8'h3f;
  localparam logic [7:0] WAKE_W1C_MASK = 8'h1f;
  localparam logic [7:0] WAKE_SRC_MASK = 8'h0f;
  localparam int SLEEP_EVENT_BIT = 5;
  localparam int KBD_BIT = 4;
  localparam int IRQ_MASTER_BIT = 7;
  localparam int WAKE_MASTER_BIT = 6;
  localparam int OPEN_DRAIN_BIT = 0;
  localparam int NUM_GPIO = 4;
  typedef enum logic [1:0] {
    EDGE_RISE,
    EDGE_FALL,
    EDGE_EITHER,
    EDGE_NONE
  } miw_edge_t;
endpackage : miw_pkg

/* File: tb_top.sv */
// Testbench: register, event and pin checks for the wake/irq group.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic standbyPorRst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdata;
  logic [3:0] gpioLine = 4'h0;
  logic kbdPortPin16 = 1'b0;
  logic kbdPortPin17 = 1'b0;
  logic mgmtIrqPinOut, mgmtIrqPinOe, wakePinOut, wakePinOe, mgmtIrqLevel, wakeLevel;
  logic kbdPin17OnLine20, kbdPin17OnLine62, miscStatusPulse, irqOut;
  logic [7:0] expQ[$];
  logic [7:0] rnd;
  logic pendRd = 1'b0;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int miscCount = 0;
  int seed = 9563;
  always #10 clk = ~clk;
  miw_irq_wake dut_u (.clk(clk), .sys_rst(sys_rst), .standbyPorRst(standbyPorRst),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .gpioLine(gpioLine), .kbdPortPin16(kbdPortPin16),
    .kbdPortPin17(kbdPortPin17), .mgmtIrqPinOut(mgmtIrqPinOut), .mgmtIrqPinOe(mgmtIrqPinOe),
    .wakePinOut(wakePinOut), .wakePinOe(wakePinOe), .kbdPin17OnLine20(kbdPin17OnLine20),
    .kbdPin17OnLine62(kbdPin17OnLine62), .miscStatusPulse(miscStatusPulse), .irqOut(irqOut));
  miw_host_model host_u (.mgmtIrqPinOut(mgmtIrqPinOut), .mgmtIrqPinOe(mgmtIrqPinOe),
    .wakePinOut(wakePinOut), .wakePinOe(wakePinOe), .mgmtIrqLevel(mgmtIrqLevel),
    .wakeLevel(wakeLevel));
  task automatic finish_test;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp1
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    expQ.push_back(e);
    @(posedge clk);
    regRead <= 1'b0;
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  always @(posedge clk) begin
    pendRd <= regRead;
    cycles <= cycles + 1;
    if (miscStatusPulse === 1'b1) miscCount <= miscCount + 1;
    // Generous ceiling: the sequence needs well under 1000 cycles
    if (cycles == 5000) begin
      n_errors++;
      finish_test();
    end
  end
  // Read data stands only in the cycle after the strobe
  always @(negedge clk) begin
    if (pendRd) begin
      if (expQ.size() == 0) n_errors++;
      else cmp8(regRdata, expQ.pop_front());
    end
  end
  initial begin
    logic [7:0] ofs [5] = '{8'h61, 8'h64, 8'h66, 8'h68, 8'h6c};
    idle(5);
    sys_rst <= 1'b0;
    standbyPorRst <= 1'b0;
    foreach (ofs[i]) rd(ofs[i], miw_pkg::REG_RESET);
    rd(8'h5a, 8'h00);
    $display("test reset_values done");
    wr(8'h61, 8'hff);
    rd(8'h61, miw_pkg::SLEEP_RW_MASK);
    rd(8'h64, 8'h20);
    wr(8'h66, 8'h20);
    wr(8'h70, 8'h80);
    idle(3);
    cmp1(mgmtIrqLevel, 1'b0);
    wr(8'h70, 8'h00);
    idle(3);
    cmp1(mgmtIrqLevel, 1'b1);
    cmp1(irqOut, 1'b1);
    wr(8'h70, 8'h80);
    wr(8'h66, 8'h1f);
    idle(3);
    cmp1(irqOut, 1'b0);
    cmp1(mgmtIrqPinOe, 1'b1);
    cmp1(mgmtIrqPinOut, 1'b1);
    wr(8'h70, 8'h81);
    idle(3);
    cmp1(mgmtIrqPinOe, 1'b0);
    wr(8'h64, 8'h20);
    rd(8'h64, 8'h00);
    $display("test sleep_irq done");
    repeat (4) begin
      rnd = 8'($random(seed));
      wr(8'h66, rnd & miw_pkg::IRQ_MASK);
      rd(8'h66, rnd & miw_pkg::IRQ_MASK);
    end
    wr(8'h66, 8'h0f);
    // Either edge on all lines, inverted polarity must not matter
    wr(8'h71, 8'haf);
    wr(8'h72, 8'ha0);
    wr(8'h6c, 8'h00);
    for (int i = 0; i < 4; i++) begin
      for (int e = 0; e < 2; e++) begin
        @(posedge clk);
        gpioLine[i] <= ~gpioLine[i];
        idle(4);
        rd(8'h64, 8'h01 << i);
        rd(8'h68, 8'h01 << i);
        cmp1(irqOut, 1'b1);
        cmp1(wakeLevel, 1'b1);
        wr(8'h64, 8'hff);
        wr(8'h68, 8'h00);
        rd(8'h68, 8'h01 << i);
        wr(8'h68, 8'h01 << i);
        rd(8'h68, 8'h00);
      end
    end
    wr(8'h6c, 8'h02);
    wr(8'h70, 8'hc0);
    @(posedge clk);
    gpioLine[1] <= ~gpioLine[1];
    idle(4);
    cmp1(wakeLevel, 1'b0);
    cmp8(8'(miscCount), 8'd9);
    $display("test gpio_events done");
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h68, 8'h02);
    @(posedge clk);
    standbyPorRst <= 1'b1;
    @(posedge clk);
    standbyPorRst <= 1'b0;
    rd(8'h68, 8'h00);
    $display("test resets done");
    wr(8'h71, 8'ha0);
    wr(8'h66, 8'h10);
    wr(8'h70, 8'h86);
    @(posedge clk);
    kbdPortPin16 <= 1'b1;
    kbdPortPin17 <= 1'b1;
    idle(4);
    rd(8'h64, 8'h10);
    cmp1(mgmtIrqLevel, 1'b0);
    cmp1(kbdPin17OnLine62, 1'b1);
    cmp1(kbdPin17OnLine20, 1'b0);
    wr(8'h70, 8'h82);
    idle(3);
    cmp1(kbdPin17OnLine20, 1'b1);
    $display("test keyboard done");
    idle(2);
    finish_test();
  end
endmodule : tb_top
